// ===== shared/ibis_ctl_if.sv
// Interface joining the top module to one priority controller.
`timescale 1ns/10ps
interface ibis_ctl_if;
    logic [7:0] request_input;
    logic [7:0] request_enable;
    logic       ctl_enable;
    logic       acknowledge_input;
    logic       req_active;
    logic [2:0] req_level;
    logic       intr_out;
    logic [2:0] served_level;
    logic       served_valid;
    modport ctl (input request_input, request_enable, ctl_enable, acknowledge_input,
                 output req_active, req_level, intr_out, served_level, served_valid);
    modport top (output request_input, request_enable, ctl_enable, acknowledge_input,
                 input req_active, req_level, intr_out, served_level, served_valid);
endinterface

// ===== shared/ibis_pkg.sv
// Package with constants and types for the board interrupt system.
package ibis_pkg;
    localparam int NUM_LINES      = 8;
    localparam int NUM_SOURCES    = 10;
    localparam int NUM_VLINES     = 8;
    localparam int RESP_BYTES_MAX = 4;
    localparam int SEL_W          = 4;
    localparam int RESP_IDX_W     = 2;
    localparam int SRC_RX_A       = 0;
    localparam int SRC_TX_A       = 1;
    localparam int SRC_DONE_A     = 2;
    localparam int SRC_RX_B       = 3;
    localparam int SRC_TX_B       = 4;
    localparam int SRC_DONE_B     = 5;
    localparam int SRC_IN_A       = 6;
    localparam int SRC_IN_B       = 7;
    localparam int SRC_OUT_A      = 8;
    localparam int SRC_OUT_B      = 9;
    localparam logic [3:0] MAP_UNUSED = 4'hF;
    localparam logic [7:0] ACK_INSTR_RESET = 8'hFF;
    localparam logic [1:0] RESP_CNT_RESET  = 2'h0;

    typedef enum logic [1:0] {
        IBIS_IDLE     = 2'b00,
        IBIS_PENDING  = 2'b01,
        IBIS_SERVING  = 2'b10
    } ibis_state_t;
endpackage

// ===== sim/ibis_host_model.sv
// Behavioural host processor that acknowledges interrupts and records the vector.
`timescale 1ns/10ps
module ibis_host_model
    import ibis_pkg::*;
#(
    parameter logic [7:0] ARB_VECTOR = 8'h5A
)
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       go,
    input  wire logic [3:0] wait_cycles,
    input  wire logic       inta_data_valid,
    input  wire logic [7:0] inta_data,
    output logic            bus_inta,
    output logic [7:0]      vector_r,
    output int              answers
);
    int         wait_cnt;
    int         hold_cnt;
    logic       got;
    logic       done;
    logic [7:0] cap_vec;
    // The answer is taken on the rising edge at which the board shows it.
    always @(posedge ref_clk) begin
        got <= go && (got || (bus_inta && inta_data_valid === 1'b1));
        if (bus_inta && inta_data_valid === 1'b1) begin
            cap_vec <= inta_data;
        end
    end
    // A silent board is given nine cycles; then the arbiter supplies its own vector.
    always @(negedge ref_clk) begin
        if (reset || !go) begin
            bus_inta <= 1'b0;
            wait_cnt <= 0;
            hold_cnt <= 0;
            done     <= 1'b0;
            if (reset) answers <= 0;
        end else if (done) begin
            bus_inta <= 1'b0;
        end else if (got) begin
            bus_inta <= 1'b0;
            done     <= 1'b1;
            vector_r <= cap_vec;
            answers  <= answers + 1;
        end else if (!bus_inta) begin
            bus_inta <= (wait_cnt >= int'(wait_cycles));
            wait_cnt <= wait_cnt + 1;
        end else if (hold_cnt == 8) begin
            bus_inta <= 1'b0;
            done     <= 1'b1;
            vector_r <= ARB_VECTOR;
            answers  <= answers + 1;
        end else begin
            hold_cnt <= hold_cnt + 1;
        end
    end
endmodule // ibis_host_model

// ===== sim/io_board_interrupt_system_tb.sv
// Self-checking testbench for the board interrupt system.
`timescale 1ns/10ps
module io_board_interrupt_system_tb;
    import ibis_pkg::*;
    localparam logic [7:0] ARB_VEC = 8'h5A;
    logic         ref_clk, reset, go, resp_read, resp_sel_b;
    logic [7:0]   control_line, line_polarity_select, enable_a, enable_b, ack_instr_base;
    logic [1:0]   serial_tx_done, serial_modem_change, input_latch_strobe, input_port_read;
    logic [1:0]   output_port_load, peripheral_ack, rx_byte_ready_in, tx_holding_free_in;
    logic [31:0]  source_priority_map;
    logic         cascade_mode, a_ranks_high, drive_pint, ack_mode_select;
    logic         ctl_enable_a, ctl_enable_b;
    logic [2:0]   vline_sel_a, vline_sel_b;
    logic [255:0] resp_bytes_a, resp_bytes_b;
    logic [1:0]   resp_count;
    logic [3:0]   wait_cycles;
    logic         bus_inta, pint_out, inta_data_valid;
    logic [7:0]   vint_out, inta_data, resp_data, vector_r;
    logic [9:0]   onboard_source_n;
    int           answers, num_errors, tests_run, valid_seen, v0;

    ibis_top ibis_top_i (.ref_clk(ref_clk), .reset(reset), .control_line(control_line),
        .line_polarity_select(line_polarity_select), .source_events(20'h0_0000),
        .serial_tx_done(serial_tx_done), .serial_modem_change(serial_modem_change),
        .input_latch_strobe(input_latch_strobe), .input_port_read(input_port_read),
        .output_port_load(output_port_load), .peripheral_ack(peripheral_ack),
        .rx_byte_ready_in(rx_byte_ready_in), .tx_holding_free_in(tx_holding_free_in),
        .source_priority_map(source_priority_map), .cascade_mode(cascade_mode),
        .a_ranks_high(a_ranks_high), .drive_pint(drive_pint),
        .ack_mode_select(ack_mode_select), .vline_sel_a(vline_sel_a),
        .vline_sel_b(vline_sel_b), .enable_a(enable_a), .enable_b(enable_b),
        .ctl_enable_a(ctl_enable_a), .ctl_enable_b(ctl_enable_b),
        .resp_bytes_a(resp_bytes_a), .resp_bytes_b(resp_bytes_b), .resp_count(resp_count),
        .ack_instr_base(ack_instr_base), .bus_inta(bus_inta), .resp_read(resp_read),
        .resp_sel_b(resp_sel_b), .pint_out(pint_out), .vint_out(vint_out),
        .inta_data(inta_data), .inta_data_valid(inta_data_valid), .resp_data(resp_data),
        .onboard_source_n(onboard_source_n));

    ibis_host_model #(.ARB_VECTOR(ARB_VEC)) ibis_host_model_i (.ref_clk(ref_clk),
        .reset(reset), .go(go), .wait_cycles(wait_cycles),
        .inta_data_valid(inta_data_valid), .inta_data(inta_data), .bus_inta(bus_inta),
        .vector_r(vector_r), .answers(answers));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (reset) begin
            valid_seen <= 0;
        end else if (inta_data_valid === 1'b1) begin
            valid_seen <= valid_seen + 1;
        end
    end

    function automatic logic [7:0] resp_byte(input logic b, input int l, input int k);
        return {b, 3'(l), 2'b00, 2'(k)};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic do_reset(input int n);
        go    = 1'b0;
        reset = 1'b1;
        tick(n);
        reset = 1'b0;
        tick(1);
    endtask
    task automatic inta_expect(input logic [7:0] exp);
        int n0;
        n0 = answers;
        go = 1'b1;
        for (int i = 0; i < 60 && answers == n0; i++) tick(1);
        if (answers == n0) begin
            num_errors++;
            report_and_stop();
        end
        check(16'(vector_r), 16'(exp));
        go = 1'b0;
        tick(2);
    endtask
    task automatic read_resp(input logic [7:0] exp);
        resp_read = 1'b1;
        tick(1);
        resp_read = 1'b0;
        tick(1);
        check(16'(resp_data), 16'(exp));
    endtask

    initial begin
        {reset, go, resp_read, resp_sel_b, control_line, line_polarity_select} = '0;
        {serial_tx_done, serial_modem_change, input_latch_strobe, input_port_read} = '0;
        {output_port_load, peripheral_ack, rx_byte_ready_in, tx_holding_free_in} = '0;
        {vline_sel_a, vline_sel_b, resp_count, wait_cycles} = '0;
        {cascade_mode, a_ranks_high, drive_pint, ack_mode_select} = 4'hF;
        {ctl_enable_a, ctl_enable_b, enable_a, enable_b} = {2'b11, 16'hFFFF};
        source_priority_map = 32'hFFFF_FFFF;
        ack_instr_base = 8'hC0;
        num_errors = 0;
        tests_run = 0;
        for (int l = 0; l < 8; l++) begin
            for (int k = 0; k < 4; k++) begin
                resp_bytes_a[(4*l+k)*8 +: 8] = resp_byte(1'b0, l, k);
                resp_bytes_b[(4*l+k)*8 +: 8] = resp_byte(1'b1, l, k);
            end
        end
        do_reset(20);
        check(16'(onboard_source_n), 16'h03FF);
        check({inta_data, resp_data}, 16'hFF00);
        // Each level in turn, with input 7 also requesting and a varied host delay.
        for (int l = 0; l < 8; l++) begin
            do_reset(2);
            line_polarity_select = 8'h38;
            control_line = ((8'h01 << l) | 8'h80) ^ 8'h38;
            wait_cycles = 4'(l);
            tick(2);
            check(16'(pint_out), 16'h0001);
            inta_expect(ack_instr_base | 8'(l));
        end
        line_polarity_select = 8'h00;
        do_reset(2);
        enable_a = 8'hFB;
        control_line = 8'h04;
        tick(3);
        check(16'(pint_out), 16'h0000);
        enable_a = 8'hFF;
        ctl_enable_a = 1'b0;
        tick(3);
        check(16'(pint_out), 16'h0000);
        ctl_enable_a = 1'b1;
        tick(3);
        check(16'(pint_out), 16'h0001);
        for (int r = 0; r < 2; r++) begin
            a_ranks_high = 1'(r);
            do_reset(2);
            source_priority_map = 32'hFFFF_FF6F;
            control_line = 8'h01;
            input_latch_strobe = 2'b01;
            tick(1);
            input_latch_strobe = 2'b00;
            tick(2);
            check(16'(onboard_source_n), 16'h03BF);
            inta_expect(r == 1 ? ack_instr_base : ack_instr_base | 8'h09);
            input_port_read = 2'b01;
            tick(1);
            input_port_read = 2'b00;
            tick(2);
            check(16'(onboard_source_n), 16'h03FF);
        end
        do_reset(2);
        {rx_byte_ready_in, tx_holding_free_in} = 4'b0110;
        {serial_tx_done, serial_modem_change} = 4'b0110;
        tick(2);
        check(16'(onboard_source_n), 16'h03CA);
        {rx_byte_ready_in, tx_holding_free_in, serial_tx_done, serial_modem_change} = '0;
        // An acknowledge with no load before it must not count as a delivery.
        for (int s = 0; s < 4; s++) begin
            {output_port_load, peripheral_ack} = (s % 2 == 1) ? 4'b1000 : 4'b0010;
            tick(1);
            {output_port_load, peripheral_ack} = 4'b0000;
            tick(2);
            check(16'(onboard_source_n), s == 2 ? 16'h01FF : 16'h03FF);
        end
        do_reset(2);
        drive_pint = 1'b0;
        vline_sel_a = 3'h4;
        control_line = 8'h02;
        tick(2);
        check({7'h00, pint_out, vint_out}, 16'h0010);
        v0 = valid_seen;
        inta_expect(ARB_VEC);
        check(16'(valid_seen - v0), 16'h0000);
        {cascade_mode, vline_sel_a, vline_sel_b} = 7'b0_101_010;
        source_priority_map = 32'hFFFF_FFF0;
        rx_byte_ready_in = 2'b01;
        control_line = 8'h08;
        resp_count = 2'h1;
        resp_sel_b = 1'b1;
        do_reset(2);
        check(16'(vint_out), 16'h0024);
        for (int k = 0; k < 3; k++) read_resp(resp_byte(1'b1, 0, k % 2));
        resp_sel_b = 1'b0;
        do_reset(2);
        read_resp(resp_byte(1'b0, 3, 0));
        ctl_enable_b = 1'b0;
        tick(2);
        check(16'(vint_out), 16'h0020);
        {cascade_mode, drive_pint, ctl_enable_b, resp_count} = 5'b111_11;
        control_line = 8'h04;
        do_reset(2);
        for (int k = 0; k < 5; k++) read_resp(resp_byte(1'b0, 2, k % 4));
        // Independent mode, then a disabled acknowledge answer: the arbiter must answer.
        v0 = valid_seen;
        for (int m = 0; m < 2; m++) begin
            {cascade_mode, ack_mode_select} = 2'(m + 1);
            inta_expect(ARB_VEC);
        end
        check(16'(valid_seen - v0), 16'h0000);
        report_and_stop();
    end
endmodule // io_board_interrupt_system_tb

// ===== src/ibis_prio_ctl.sv
// Eight-input fixed priority controller with masking and acknowledge capture.
`timescale 1ns/10ps
module ibis_prio_ctl
    import ibis_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  reset,
    ibis_ctl_if.ctl    bus
);
    logic [7:0] pend;
    logic [2:0] lvl;
    logic       act;
    logic [2:0] served_r;
    logic [2:0] served_nxt;
    logic       sval_r;
    logic       sval_nxt;
    logic       ack_d_r;
    logic       ack_d_nxt;

    // Input 0 wins; requests are masked per input and by the controller enable.
    always_comb begin
        pend = bus.request_input & bus.request_enable & {8{bus.ctl_enable}};
        act  = |pend;
        lvl  = 3'h0;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (pend[i]) begin
                lvl = i[2:0];
            end
        end
    end

    always_comb begin
        ack_d_nxt  = bus.acknowledge_input;
        served_nxt = served_r;
        sval_nxt   = sval_r;
        if (bus.acknowledge_input && !ack_d_r && act) begin
            served_nxt = lvl;
            sval_nxt   = 1'b1;
        end else if (!act) begin
            sval_nxt   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            served_r <= 3'h0;
            sval_r   <= 1'b0;
            ack_d_r  <= 1'b0;
        end else begin
            served_r <= served_nxt;
            sval_r   <= sval_nxt;
            ack_d_r  <= ack_d_nxt;
        end
    end

    assign bus.req_active   = act;
    assign bus.req_level    = lvl;
    assign bus.intr_out     = act;
    assign bus.served_level = served_r;
    assign bus.served_valid = sval_r;

    property p_mask;
        @(posedge ref_clk) disable iff (reset)
        !bus.ctl_enable |-> !bus.intr_out;
    endproperty
    a_mask: assert property (p_mask) else $error("Disabled controller interrupts.");

    property p_top_prio;
        @(posedge ref_clk) disable iff (reset)
        (pend[0]) |-> (bus.req_level == 3'h0);
    endproperty
    a_top_prio: assert property (p_top_prio) else $error("Input 0 not highest.");
endmodule // ibis_prio_ctl

// ===== src/ibis_top.sv
// Board interrupt system: polarity, source routing, cascade and response bytes.
`timescale 1ns/10ps
module ibis_top
    import ibis_pkg::*;
(
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    input  wire logic [NUM_LINES-1:0]          control_line,
    input  wire logic [NUM_LINES-1:0]          line_polarity_select,
    input  wire logic [2*NUM_SOURCES-1:0]      source_events,
    input  wire logic [1:0]                    serial_tx_done,
    input  wire logic [1:0]                    serial_modem_change,
    input  wire logic [1:0]                    input_latch_strobe,
    input  wire logic [1:0]                    input_port_read,
    input  wire logic [1:0]                    output_port_load,
    input  wire logic [1:0]                    peripheral_ack,
    input  wire logic [1:0]                    rx_byte_ready_in,
    input  wire logic [1:0]                    tx_holding_free_in,
    input  wire logic [8*SEL_W-1:0]            source_priority_map,
    input  wire logic                          cascade_mode,
    input  wire logic                          a_ranks_high,
    input  wire logic                          drive_pint,
    input  wire logic                          ack_mode_select,
    input  wire logic [2:0]                    vline_sel_a,
    input  wire logic [2:0]                    vline_sel_b,
    input  wire logic [7:0]                    enable_a,
    input  wire logic [7:0]                    enable_b,
    input  wire logic                          ctl_enable_a,
    input  wire logic                          ctl_enable_b,
    input  wire logic [8*8*RESP_BYTES_MAX-1:0] resp_bytes_a,
    input  wire logic [8*8*RESP_BYTES_MAX-1:0] resp_bytes_b,
    input  wire logic [RESP_IDX_W-1:0]         resp_count,
    input  wire logic [7:0]                    ack_instr_base,
    input  wire logic                          bus_inta,
    input  wire logic                          resp_read,
    input  wire logic                          resp_sel_b,
    output logic                               pint_out,
    output logic [NUM_VLINES-1:0]              vint_out,
    output logic [7:0]                         inta_data,
    output logic                               inta_data_valid,
    output logic [7:0]                         resp_data,
    output logic [9:0]                         onboard_source_n
);
    ibis_ctl_if ctl_a ();
    ibis_ctl_if ctl_b ();

    logic [9:0]       src_n;
    logic [1:0]       in_flag_r;
    logic [1:0]       in_flag_nxt;
    logic [1:0]       out_flag_r;
    logic [1:0]       out_flag_nxt;
    logic [1:0]       out_loaded_r;
    logic [1:0]       out_loaded_nxt;
    logic [1:0]       done_flag_r;
    logic [1:0]       done_flag_nxt;
    logic [7:0]       b_req;
    logic             ack_a;
    logic             ack_b;
    logic             win_b;
    logic [2:0]       win_lvl;
    logic             any_req;
    logic [7:0]       inta_r;
    logic [7:0]       inta_nxt;
    logic             inta_v_r;
    logic             inta_v_nxt;
    logic [7:0]       resp_r;
    logic [7:0]       resp_nxt;
    logic [1:0]       ridx_r;
    logic [1:0]       ridx_nxt;
    logic             rsrc_b;
    logic [2:0]       rlvl;
    ibis_state_t      st_r;
    ibis_state_t      st_nxt;

    // Picks one byte out of a packed table of four bytes per level.
    function automatic logic [7:0] pick_byte(input logic [8*8*RESP_BYTES_MAX-1:0] tbl,
                                             input logic [2:0] lvl,
                                             input logic [1:0] idx);
        logic [4:0] k;
        k = {lvl, idx};
        pick_byte = tbl[k*8 +: 8];
    endfunction

    // Hardware events set the sticky source flags; a set in the clearing cycle wins.
    always_comb begin
        in_flag_nxt    = in_flag_r;
        out_flag_nxt   = out_flag_r;
        out_loaded_nxt = out_loaded_r;
        done_flag_nxt  = done_flag_r;
        for (int p = 0; p < 2; p++) begin
            if (input_port_read[p]) in_flag_nxt[p] = 1'b0;
            if (input_latch_strobe[p]) in_flag_nxt[p] = 1'b1;
            if (output_port_load[p]) begin
                out_flag_nxt[p]   = 1'b0;
                out_loaded_nxt[p] = 1'b1;
            end
            // An acknowledge for the previous load still counts when a new load coincides.
            if (peripheral_ack[p] && out_loaded_r[p]) begin
                out_flag_nxt[p]   = 1'b1;
                out_loaded_nxt[p] = output_port_load[p];
            end
            // The done flag follows the serial port and clears one cycle after both serial events drop.
            done_flag_nxt[p] = serial_tx_done[p] | serial_modem_change[p];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            in_flag_r    <= 2'h0;
            out_flag_r   <= 2'h0;
            out_loaded_r <= 2'h0;
            done_flag_r  <= 2'h0;
        end else begin
            in_flag_r    <= in_flag_nxt;
            out_flag_r   <= out_flag_nxt;
            out_loaded_r <= out_loaded_nxt;
            done_flag_r  <= done_flag_nxt;
        end
    end

    // Active low onboard sources, then routing through the map into controller B.
    always_comb begin
        src_n             = 10'h3FF;
        src_n[SRC_RX_A]   = ~rx_byte_ready_in[0];
        src_n[SRC_RX_B]   = ~rx_byte_ready_in[1];
        src_n[SRC_TX_A]   = ~tx_holding_free_in[0];
        src_n[SRC_TX_B]   = ~tx_holding_free_in[1];
        src_n[SRC_DONE_A] = ~done_flag_r[0];
        src_n[SRC_DONE_B] = ~done_flag_r[1];
        src_n[SRC_IN_A]   = ~in_flag_r[0];
        src_n[SRC_IN_B]   = ~in_flag_r[1];
        src_n[SRC_OUT_A]  = ~out_flag_r[0];
        src_n[SRC_OUT_B]  = ~out_flag_r[1];
        for (int i = 0; i < 8; i++) begin
            logic [3:0] s;
            s = source_priority_map[i*SEL_W +: SEL_W];
            // Map values above nine or the unused code leave the input idle.
            b_req[i] = (s != MAP_UNUSED && s < 4'hA) ? ~src_n[s] : 1'b0;
        end
    end

    // The map and mode pins are jumper-like straps and must not change while running.
    assign ctl_a.request_input  = control_line ^ line_polarity_select;
    assign ctl_a.request_enable = enable_a;
    assign ctl_a.ctl_enable     = ctl_enable_a;
    assign ctl_b.request_input  = b_req;
    assign ctl_b.request_enable = enable_b;
    assign ctl_b.ctl_enable     = ctl_enable_b;

    // In cascade both controllers see one acknowledge; otherwise only the one chosen by resp_sel_b.
    always_comb begin
        win_b   = ctl_b.req_active && (!ctl_a.req_active || !a_ranks_high);
        win_lvl = win_b ? ctl_b.req_level : ctl_a.req_level;
        any_req = ctl_a.req_active | ctl_b.req_active;
        ack_a   = cascade_mode ? bus_inta : (bus_inta && !resp_sel_b);
        ack_b   = cascade_mode ? bus_inta : (bus_inta && resp_sel_b);
    end

    assign ctl_a.acknowledge_input = ack_a;
    assign ctl_b.acknowledge_input = ack_b;

    ibis_prio_ctl u_ctl_a (
        .ref_clk (ref_clk),
        .reset   (reset),
        .bus     (ctl_a)
    );

    ibis_prio_ctl u_ctl_b (
        .ref_clk (ref_clk),
        .reset   (reset),
        .bus     (ctl_b)
    );

    // Output line selection per mode.
    always_comb begin
        pint_out = 1'b0;
        vint_out = 8'h00;
        if (cascade_mode) begin
            if (drive_pint) begin
                pint_out = any_req;
            end else begin
                vint_out[vline_sel_a] = any_req;
            end
        end else begin
            vint_out[vline_sel_a] = ctl_a.intr_out;
            vint_out[vline_sel_b] = vint_out[vline_sel_b] | ctl_b.intr_out;
        end
    end

    // Acknowledge answer and software response reads.
    always_comb begin
        st_nxt     = st_r;
        inta_nxt   = inta_r;
        inta_v_nxt = 1'b0;
        resp_nxt   = resp_r;
        ridx_nxt   = ridx_r;
        rsrc_b     = cascade_mode ? win_b : resp_sel_b;
        rlvl       = rsrc_b ? ctl_b.req_level : ctl_a.req_level;
        case (st_r)
            IBIS_IDLE: begin
                if (any_req) st_nxt = IBIS_PENDING;
            end
            IBIS_PENDING: begin
                // Vectored operation leaves the acknowledge to the external arbiter.
                if (bus_inta && ack_mode_select && drive_pint && cascade_mode) begin
                    inta_nxt   = ack_instr_base | {4'h0, win_b, win_lvl};
                    inta_v_nxt = 1'b1;
                    st_nxt     = IBIS_SERVING;
                end else if (!any_req) begin
                    st_nxt = IBIS_IDLE;
                end
            end
            IBIS_SERVING: begin
                if (!bus_inta) st_nxt = any_req ? IBIS_PENDING : IBIS_IDLE;
            end
            default: st_nxt = IBIS_IDLE;
        endcase
        if (resp_read) begin
            resp_nxt = pick_byte(rsrc_b ? resp_bytes_b : resp_bytes_a, rlvl, ridx_r);
            ridx_nxt = (ridx_r == resp_count) ? 2'h0 : ridx_r + 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r     <= IBIS_IDLE;
            inta_r   <= ACK_INSTR_RESET;
            inta_v_r <= 1'b0;
            resp_r   <= 8'h00;
            ridx_r   <= RESP_CNT_RESET;
        end else begin
            st_r     <= st_nxt;
            inta_r   <= inta_nxt;
            inta_v_r <= inta_v_nxt;
            resp_r   <= resp_nxt;
            ridx_r   <= ridx_nxt;
        end
    end

    assign inta_data        = inta_r;
    assign inta_data_valid  = inta_v_r;
    assign resp_data        = resp_r;
    assign onboard_source_n = src_n;

    property p_no_inta_vec;
        @(posedge ref_clk) disable iff (reset)
        !(drive_pint && cascade_mode) |=> !inta_data_valid;
    endproperty
    a_no_inta_vec: assert property (p_no_inta_vec) else $error("Answered in vectored mode.");

    property p_one_line;
        @(posedge ref_clk) disable iff (reset)
        cascade_mode |-> ($countones({pint_out, vint_out}) <= 1);
    endproperty
    a_one_line: assert property (p_one_line) else $error("Cascade drives two lines.");

    property p_in_clear;
        @(posedge ref_clk) disable iff (reset)
        (input_port_read[0] && !input_latch_strobe[0]) |=> onboard_source_n[SRC_IN_A];
    endproperty
    a_in_clear: assert property (p_in_clear) else $error("Input flag not cleared.");

    property p_polarity;
        @(posedge ref_clk) disable iff (reset)
        ctl_a.request_input == (control_line ^ line_polarity_select);
    endproperty
    a_polarity: assert property (p_polarity) else $error("Polarity wrong.");

    property p_a_high;
        @(posedge ref_clk) disable iff (reset)
        (cascade_mode && a_ranks_high && ctl_a.req_active) |-> !win_b;
    endproperty
    a_a_high: assert property (p_a_high) else $error("Rank order wrong.");

    property p_ack_common;
        @(posedge ref_clk) disable iff (reset)
        cascade_mode |-> (ack_a == ack_b);
    endproperty
    a_ack_common: assert property (p_ack_common) else $error("Acks differ.");

    sequence s_inta_req;
        cascade_mode && drive_pint && ack_mode_select && bus_inta && st_r == IBIS_PENDING;
    endsequence
    property p_inta;
        @(posedge ref_clk) disable iff (reset)
        s_inta_req |=> inta_data_valid ##1 !inta_data_valid;
    endproperty
    a_inta: assert property (p_inta) else $error("Instruction byte missing.");

    property p_out_set;
        @(posedge ref_clk) disable iff (reset)
        (peripheral_ack[0] && out_loaded_r[0] && !output_port_load[0])
            |=> !onboard_source_n[SRC_OUT_A];
    endproperty
    a_out_set: assert property (p_out_set) else $error("Delivered flag not set.");
endmodule // ibis_top
